// ### verilog/afs_port_select.sv
// Operation
// - Reset and default: transmit pin carries serial
// - Pulse mode: idle high, 250ms low per tick
// - Normal dimming: full brightness gives 100% duty
// - Inverted dimming: full brightness gives 0% duty
// - Dimming waveform fixed at 160Hz
// - Virtual load: pin follows load switch
// - Alternative modes yield to incoming serial data
// - After reception ends, restore selected function
// - Remote mode: 0V stops, 5V/command charges
// - Load config mode: sense jumper on pin
// - Inverted load control: 0V on, 5V off
// - Normal load control: 0V off, 5V on
// - Relay on joins C-NO, off C-NC
// - Relay moves after 10s unbroken condition
// - Always-off relay mode overrides everything
// - Panel-high mode: relay on at excess voltage
// - Panel-high uses set and clear hysteresis
// - Dimming follows lighting timer dim level
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
module afs_port_select #(
	parameter int unsigned PULSE_CYC      = afs_pkg::PULSE_CYC,       // Energy pulse low time
	parameter int unsigned PWM_STEP_CYC   = afs_pkg::PWM_STEP_CYC,    // Cycles per dimming slot
	parameter int unsigned RELAY_HOLD_CYC = afs_pkg::RELAY_HOLD_CYC,  // Relay persistence
	parameter int unsigned RX_IDLE_CYC    = afs_pkg::RX_IDLE_CYC      // Quiet time ending reception
) (
	input  wire logic        SYS_CLK,        // System clock, 50 MHz
	input  wire logic        RST_B,          // Asynchronous reset, active low
	input  wire logic [3:0]  ADDR,           // Register address
	input  wire logic [15:0] WR_DATA,        // Register write data
	input  wire logic        WR_EN,          // Write strobe
	input  wire logic        RD_EN,          // Read strobe
	output logic      [15:0] RD_DATA,        // Read data, cycle after the strobe
	input  wire logic        RX_PIN,         // Receive pin level
	output logic             TX_PIN,         // Transmit pin level
	input  wire logic        UART_TXD,       // Serial transmit data from the core
	input  wire logic        ENERGY_TICK,    // One pulse per 0.01 kWh harvested
	input  wire logic [6:0]  DIM_PCT,        // Timer program dim level, percent
	input  wire logic        LOAD_STATE,     // Load output switch state
	input  wire logic        REMOTE_ON_CMD,  // On command from the serial link
	input  wire logic [15:0] PANEL_V,        // Panel voltage reading
	output logic             CHARGE_EN,      // Charger allowed to run
	output logic             LOAD_ON_REQ,    // Load output permitted by the pin
	output logic             LOAD_JUMPER,    // Jumper sensed on the pin
	output logic             RELAY_ON        // Relay drive, high joins C to NO
);

	localparam int unsigned PW = (PULSE_CYC > 1) ? $clog2(PULSE_CYC) : 1;
	localparam int unsigned IW = (RX_IDLE_CYC > 1) ? $clog2(RX_IDLE_CYC) : 1;
	localparam logic [PW-1:0] PULSE_LAST = PW'(PULSE_CYC - 1);
	localparam logic [IW-1:0] IDLE_LAST  = IW'(RX_IDLE_CYC - 1);
	localparam logic [afs_pkg::PEND_W-1:0] PEND_MAX = '1;

	// Refuse counts the counters cannot serve
	if ((PULSE_CYC < 1) || (RX_IDLE_CYC < 1)) begin : g_chk
		$error("afs_port_select: counts must be at least 1");
	end

	// True for the transmit functions that give way to serial traffic
	function automatic logic is_alt(input afs_pkg::afs_tx_mode_t m);
		is_alt = (m == afs_pkg::TX_PULSE) || (m == afs_pkg::TX_PWM_NORM) ||
			(m == afs_pkg::TX_PWM_INV) || (m == afs_pkg::TX_VLOAD);
	endfunction

	// True for relay modes that force the relay off
	function automatic logic rly_forced(input afs_pkg::afs_rly_mode_t m);
		rly_forced = (m == afs_pkg::RLY_OFF) || (m == afs_pkg::RLY_RSVD);
	endfunction

	// Registers
	afs_pkg::afs_ctrl_t ctrl_q;       // Pin and relay function selection
	logic [15:0]        pv_set_q;     // Panel high set level
	logic [15:0]        pv_clr_q;     // Panel high clear level
	logic [15:0]        rd_data_q;    // Read data
	logic               rx_m_q;       // Receive pin, first sync stage
	logic               rx_s_q;       // Receive pin, synchronised
	logic               rx_busy_q;    // Serial reception in progress
	logic [IW-1:0]      idle_q;       // Quiet cycles during reception
	logic               pulse_act_q;  // Energy pulse being driven low
	logic [PW-1:0]      pulse_q;      // Cycles into the energy pulse
	logic [afs_pkg::PEND_W-1:0] pend_q;  // Energy pulses still owed
	logic               pv_high_q;    // Panel voltage excessive
	logic               tx_q;         // Transmit pin level
	logic               charge_q;     // Charger enable
	logic               load_q;       // Load permission
	logic               jumper_q;     // Jumper sense

	// Next values and decode
	logic                 wr_ctrl;
	logic                 wr_set;
	logic                 wr_clr;
	logic                 tx_alt;
	logic                 pwm_raw;
	logic                 alt_level;
	logic                 tx_d;
	logic                 pulse_start;
	logic                 pulse_end;
	logic                 pv_high_d;
	logic                 charge_d;
	logic                 load_d;
	logic                 relay_want;
	logic                 relay_q;
	logic [15:0]          rd_mux;
	afs_pkg::afs_status_t status;

	// Register write decode
	assign wr_ctrl = WR_EN && (ADDR == afs_pkg::OFS_CTRL);
	assign wr_set  = WR_EN && (ADDR == afs_pkg::OFS_PV_SET);
	assign wr_clr  = WR_EN && (ADDR == afs_pkg::OFS_PV_CLR);

	// Software-written registers
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_q   <= afs_pkg::CTRL_RST;
			pv_set_q <= afs_pkg::PV_SET_RST;
			pv_clr_q <= afs_pkg::PV_CLR_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= afs_pkg::afs_ctrl_t'(WR_DATA[afs_pkg::CTRL_W-1:0]);
			end
			if (wr_set) begin
				pv_set_q <= WR_DATA;
			end
			if (wr_clr) begin
				pv_clr_q <= WR_DATA;
			end
		end
	end

	// Status word and read selection; unmapped offsets read zero
	assign status = '{pending: pend_q, relay_on: relay_q, pv_high: pv_high_q, jumper: jumper_q,
		load_on: load_q, charge_en: charge_q, tx_level: tx_q, rx_busy: rx_busy_q, rx_level: rx_s_q};
	assign rd_mux = (ADDR == afs_pkg::OFS_CTRL)   ? {9'h000, ctrl_q} :
			(ADDR == afs_pkg::OFS_STATUS) ? status :
			(ADDR == afs_pkg::OFS_PV_SET) ? pv_set_q :
			(ADDR == afs_pkg::OFS_PV_CLR) ? pv_clr_q : 16'h0000;

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rd_data_q <= 16'h0000;
		end else begin
			rd_data_q <= RD_EN ? rd_mux : 16'h0000;
		end
	end

	// Two-stage synchroniser on the receive pin
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rx_m_q <= 1'b1;
			rx_s_q <= 1'b1;
		end else begin
			rx_m_q <= RX_PIN;
			rx_s_q <= rx_m_q;
		end
	end

	// A low level opens a reception; a long quiet high closes it
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rx_busy_q <= 1'b0;
			idle_q    <= '0;
		end else if (!rx_s_q) begin
			rx_busy_q <= 1'b1;
			idle_q    <= '0;
		end else if (rx_busy_q && (idle_q == IDLE_LAST)) begin
			rx_busy_q <= 1'b0;
			idle_q    <= '0;
		end else if (rx_busy_q) begin
			idle_q    <= idle_q + IW'(1);
		end
	end

	// Energy pulse scheduling; up to 255 owed pulses are kept, and ticks beyond that count are dropped
	assign pulse_start = (ctrl_q.tx == afs_pkg::TX_PULSE) && !pulse_act_q && (pend_q != '0);
	assign pulse_end   = pulse_act_q && (pulse_q == PULSE_LAST);

	// Owed pulse count; a tick in the cycle a pulse starts is still counted
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			pend_q <= '0;
		end else if (ctrl_q.tx != afs_pkg::TX_PULSE) begin
			pend_q <= '0;
		end else if (ENERGY_TICK && !pulse_start && (pend_q != PEND_MAX)) begin
			pend_q <= pend_q + afs_pkg::PEND_W'(1);
		end else if (!ENERGY_TICK && pulse_start) begin
			pend_q <= pend_q - afs_pkg::PEND_W'(1);
		end
	end

	// Low-pulse timer
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			pulse_act_q <= 1'b0;
			pulse_q     <= '0;
		end else if (pulse_start) begin
			pulse_act_q <= 1'b1;
			pulse_q     <= '0;
		end else if (pulse_end) begin
			pulse_act_q <= 1'b0;
			pulse_q     <= '0;
		end else if (pulse_act_q) begin
			pulse_q     <= pulse_q + PW'(1);
		end
	end

	// Dimming waveform from the timer program's dim level
	afs_pwm_gen #(
		.STEP_CYC (PWM_STEP_CYC)
	) u_pwm (
		.clk   (SYS_CLK),
		.rst_b (RST_B),
		.dim   (DIM_PCT),
		.pwm_q (pwm_raw)
	);

	// Transmit pin selection; reception forces serial traffic through
	assign tx_alt    = is_alt(ctrl_q.tx);
	assign alt_level = (ctrl_q.tx == afs_pkg::TX_PULSE)    ? ~pulse_act_q :
			(ctrl_q.tx == afs_pkg::TX_PWM_NORM) ? pwm_raw :
			(ctrl_q.tx == afs_pkg::TX_PWM_INV)  ? ~pwm_raw :
			LOAD_STATE;
	assign tx_d      = (tx_alt && !rx_busy_q) ? alt_level : UART_TXD;

	// Receive pin functions
	assign charge_d = (ctrl_q.rx == afs_pkg::RX_REMOTE) ? (rx_s_q || REMOTE_ON_CMD) : 1'b1;
	assign load_d   = (ctrl_q.rx == afs_pkg::RX_LOAD_INV) ? !rx_s_q :
			(ctrl_q.rx == afs_pkg::RX_LOAD_NRM) ? rx_s_q : 1'b1;

	// Panel high with set and clear levels
	assign pv_high_d = (PANEL_V > pv_set_q) ? 1'b1 :
			(PANEL_V < pv_clr_q) ? 1'b0 : pv_high_q;

	// Pin outputs and panel flag
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			tx_q      <= 1'b1;
			charge_q  <= 1'b0;
			load_q    <= 1'b0;
			jumper_q  <= 1'b0;
			pv_high_q <= 1'b0;
		end else begin
			tx_q      <= tx_d;
			charge_q  <= charge_d;
			load_q    <= load_d;
			jumper_q  <= (ctrl_q.rx == afs_pkg::RX_LOAD_CFG) && !rx_s_q;
			pv_high_q <= pv_high_d;
		end
	end

	// Relay request by mode
	assign relay_want = (ctrl_q.relay == afs_pkg::RLY_PV_HIGH) ? pv_high_q :
			(ctrl_q.relay == afs_pkg::RLY_LOAD) ? LOAD_STATE : 1'b0;

	// Persistence filter drives the relay coil
	afs_persist #(
		.HOLD_CYC (RELAY_HOLD_CYC)
	) u_relay (
		.clk       (SYS_CLK),
		.rst_b     (RST_B),
		.want      (relay_want),
		.force_off (rly_forced(ctrl_q.relay)),
		.state_q   (relay_q)
	);

	// Outputs, all from flip-flops; relay high selects the NO contact
	assign TX_PIN      = tx_q;
	assign CHARGE_EN   = charge_q;
	assign LOAD_ON_REQ = load_q;
	assign LOAD_JUMPER = jumper_q;
	assign RELAY_ON    = relay_q;
	assign RD_DATA     = rd_data_q;

	sequence s_pulse_last;
		pulse_act_q && (pulse_q == PULSE_LAST);
	endsequence

	// The release edge still loads reset values, so attempts there are left out
	tx_default_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		(RST_B && !tx_alt) |=> (TX_PIN == $past(UART_TXD)))
		else $error("serial traffic not on transmit pin");

	pulse_len_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		$fell(pulse_act_q) |-> ($past(pulse_q) == PULSE_LAST))
		else $error("energy pulse length wrong");

	pulse_end_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		s_pulse_last ##1 (!rx_busy_q && (ctrl_q.tx == afs_pkg::TX_PULSE)) |=> TX_PIN)
		else $error("transmit pin not high after pulse");

	pwm_inv_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		((ctrl_q.tx == afs_pkg::TX_PWM_INV) && !rx_busy_q && pwm_raw) |=> !TX_PIN)
		else $error("inverted dimming level wrong");

	vload_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		((ctrl_q.tx == afs_pkg::TX_VLOAD) && !rx_busy_q) |=> (TX_PIN == $past(LOAD_STATE)))
		else $error("virtual load not on transmit pin");

	rx_revert_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		(tx_alt && rx_busy_q) |=> (TX_PIN == $past(UART_TXD)))
		else $error("reception did not restore serial traffic");

	rx_done_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		(rx_busy_q && rx_s_q && (idle_q == IDLE_LAST)) |=> !rx_busy_q)
		else $error("reception did not end after quiet time");

	remote_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		(RST_B && (ctrl_q.rx == afs_pkg::RX_REMOTE)) |=> (CHARGE_EN == $past(rx_s_q || REMOTE_ON_CMD)))
		else $error("remote on/off wrong");

	jumper_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		(ctrl_q.rx == afs_pkg::RX_LOAD_CFG) |=> (LOAD_JUMPER == !$past(rx_s_q)))
		else $error("jumper sense wrong");

	load_inv_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		(ctrl_q.rx == afs_pkg::RX_LOAD_INV) |=> (LOAD_ON_REQ == !$past(rx_s_q)))
		else $error("inverted load control wrong");

	load_nrm_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		(ctrl_q.rx == afs_pkg::RX_LOAD_NRM) |=> (LOAD_ON_REQ == $past(rx_s_q)))
		else $error("normal load control wrong");

	pv_hyst_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		(!(PANEL_V > pv_set_q) && !(PANEL_V < pv_clr_q)) |=> (pv_high_q == $past(pv_high_q)))
		else $error("panel flag moved inside hysteresis");

	pv_set_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
		(PANEL_V > pv_set_q) |=> pv_high_q)
		else $error("panel high not flagged");

endmodule

// ### inc/afs_pkg.sv
package afs_pkg;

	// System clock rate
	localparam int unsigned CLK_HZ         = 50_000_000;

	// Energy pulse length on the transmit pin
	localparam int unsigned PULSE_MS       = 250;
	localparam int unsigned PULSE_CYC      = (CLK_HZ / 1000) * PULSE_MS;

	// Dimming waveform rate and one-percent step
	localparam int unsigned PWM_HZ         = 160;
	localparam int unsigned PWM_STEPS      = 100;
	localparam int unsigned PWM_STEP_CYC   = CLK_HZ / (PWM_HZ * PWM_STEPS);

	// Relay persistence time, a least time
	localparam int unsigned RELAY_HOLD_S   = 10;
	localparam int unsigned RELAY_HOLD_CYC = CLK_HZ * RELAY_HOLD_S;

	// Quiet time on the receive pin that ends a reception
	localparam int unsigned RX_IDLE_US     = 1000;
	localparam int unsigned RX_IDLE_CYC    = (CLK_HZ / 1_000_000) * RX_IDLE_US;

	// Register port geometry
	localparam int unsigned ADDR_W         = 4;
	localparam int unsigned DATA_W         = 16;

	// Register offsets
	localparam logic [3:0]  OFS_CTRL       = 4'h0;
	localparam logic [3:0]  OFS_STATUS     = 4'h1;
	localparam logic [3:0]  OFS_PV_SET     = 4'h2;
	localparam logic [3:0]  OFS_PV_CLR     = 4'h3;

	// Pending energy pulse counter width
	localparam int unsigned PEND_W         = 8;

	// Transmit pin functions
	typedef enum logic [2:0] {
		TX_NORMAL   = 3'h0,
		TX_PULSE    = 3'h1,
		TX_PWM_NORM = 3'h2,
		TX_PWM_INV  = 3'h3,
		TX_VLOAD    = 3'h4
	} afs_tx_mode_t;

	// Receive pin functions
	typedef enum logic [1:0] {
		RX_REMOTE   = 2'h0,
		RX_LOAD_CFG = 2'h1,
		RX_LOAD_INV = 2'h2,
		RX_LOAD_NRM = 2'h3
	} afs_rx_mode_t;

	// Relay modes
	typedef enum logic [1:0] {
		RLY_OFF     = 2'h0,
		RLY_PV_HIGH = 2'h1,
		RLY_LOAD    = 2'h2,
		RLY_RSVD    = 2'h3
	} afs_rly_mode_t;

	// Control register layout, low bits of the word
	typedef struct packed {
		afs_rly_mode_t relay;
		afs_rx_mode_t  rx;
		afs_tx_mode_t  tx;
	} afs_ctrl_t;

	localparam int unsigned CTRL_W         = 7;
	localparam afs_ctrl_t   CTRL_RST       = '{relay: RLY_OFF, rx: RX_REMOTE, tx: TX_NORMAL};
	localparam logic [15:0] PV_SET_RST     = 16'hFFFF;
	localparam logic [15:0] PV_CLR_RST     = 16'h0000;

	// Status register layout, sixteen bits
	typedef struct packed {
		logic [7:0] pending;
		logic       relay_on;
		logic       pv_high;
		logic       jumper;
		logic       load_on;
		logic       charge_en;
		logic       tx_level;
		logic       rx_busy;
		logic       rx_level;
	} afs_status_t;

endpackage

// ### verilog/afs_pwm_gen.sv
`timescale 1ns/1ns
module afs_pwm_gen #(
	parameter int unsigned STEP_CYC = afs_pkg::PWM_STEP_CYC  // Cycles per one-percent slot
) (
	input  wire logic       clk,    // System clock
	input  wire logic       rst_b,  // Asynchronous reset, active low
	input  wire logic [6:0] dim,    // Requested brightness in percent
	output logic            pwm_q   // Non-inverted waveform
);

	localparam int unsigned SW = (STEP_CYC > 1) ? $clog2(STEP_CYC) : 1;
	localparam logic [SW-1:0] STEP_LAST = SW'(STEP_CYC - 1);
	localparam logic [6:0]    PCT_LAST  = 7'(afs_pkg::PWM_STEPS - 1);
	localparam logic [6:0]    PCT_FULL  = 7'(afs_pkg::PWM_STEPS);

	// Refuse a step length the counter cannot serve
	if (STEP_CYC < 1) begin : g_chk
		$error("afs_pwm_gen: STEP_CYC must be at least 1");
	end

	logic [SW-1:0] step_q;  // Position inside a slot
	logic [6:0]    pct_q;   // Slot index, 0 to 99
	logic [6:0]    dim_c;   // Brightness clamped to full
	logic          step_end;

	// Requests above full brightness act as full
	assign dim_c    = (dim > PCT_FULL) ? PCT_FULL : dim;
	assign step_end = (step_q == STEP_LAST);

	// Free-running counters fix the period whatever the brightness
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			step_q <= '0;
			pct_q  <= '0;
		end else if (step_end) begin
			step_q <= '0;
			pct_q  <= (pct_q == PCT_LAST) ? 7'h00 : pct_q + 7'h01;
		end else begin
			step_q <= step_q + SW'(1);
		end
	end

	// High for dim slots out of a hundred, so duty tracks the percentage
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pwm_q <= 1'b0;
		end else begin
			pwm_q <= (pct_q < dim_c);
		end
	end

	sequence s_period_end;
		step_end && (pct_q == PCT_LAST);
	endsequence

	pwm_wrap_a: assert property (@(posedge clk) disable iff (!rst_b)
		s_period_end |=> (pct_q == 7'h00) && (step_q == '0))
		else $error("dimming period did not restart");

	pwm_full_a: assert property (@(posedge clk) disable iff (!rst_b)
		(dim_c == PCT_FULL) ##1 (dim_c == PCT_FULL) |-> ##1 pwm_q)
		else $error("full brightness did not give full duty");

endmodule

// ### verilog/afs_persist.sv
`timescale 1ns/1ns
module afs_persist #(
	parameter int unsigned HOLD_CYC = afs_pkg::RELAY_HOLD_CYC  // Cycles a change must persist
) (
	input  wire logic clk,        // System clock
	input  wire logic rst_b,      // Asynchronous reset, active low
	input  wire logic want,       // Requested relay position
	input  wire logic force_off,  // Hold off at once
	output logic      state_q     // Relay position, high for on
);

	localparam int unsigned CW = (HOLD_CYC > 1) ? $clog2(HOLD_CYC) : 1;
	localparam logic [CW-1:0] HOLD_LAST = CW'(HOLD_CYC - 1);

	// Refuse a hold time the counter cannot serve
	if (HOLD_CYC < 1) begin : g_chk
		$error("afs_persist: HOLD_CYC must be at least 1");
	end

	logic [CW-1:0] cnt_q;  // Cycles the differing request has lasted

	// Count an unbroken difference, flip once it has lasted the hold time
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= 1'b0;
			cnt_q   <= '0;
		end else if (force_off) begin
			state_q <= 1'b0;
			cnt_q   <= '0;
		end else if (want == state_q) begin
			cnt_q   <= '0;
		end else if (cnt_q == HOLD_LAST) begin
			state_q <= want;
			cnt_q   <= '0;
		end else begin
			cnt_q   <= cnt_q + CW'(1);
		end
	end

	rly_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		($changed(state_q) && !$past(force_off)) |-> ($past(cnt_q) == HOLD_LAST))
		else $error("relay moved before hold time");

	rly_force_a: assert property (@(posedge clk) disable iff (!rst_b)
		force_off |=> !state_q)
		else $error("relay not held off");

	rly_restart_a: assert property (@(posedge clk) disable iff (!rst_b)
		(!force_off && (want == state_q)) |=> (cnt_q == '0))
		else $error("persistence timer did not restart");

endmodule

// ### dv/afs_far_model.sv
`timescale 1ns/1ns
module afs_far_model (
	input  wire logic       clk,       // System clock
	input  wire logic       rst_b,     // Asynchronous reset, active low
	input  wire logic       tx_pin,    // Transmit pin at the far end
	input  wire logic       rx_lvl,    // Level the far switch presents
	output logic            rx_pin,    // Receive pin, 0V or +5V
	output logic      [7:0] low_len_q  // Width of the last low pulse
);
	logic [7:0] run_q;  // Cycles low so far

	// Far switch gives a firm 0V or +5V, never a floating level
	assign rx_pin = rx_lvl;

	// Meter times each low pulse and latches its width when the pin rises
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			run_q     <= 8'h00;
			low_len_q <= 8'h00;
		end else if (!tx_pin) begin
			run_q <= run_q + 8'h01;
		end else begin
			if (run_q != 8'h00) begin
				low_len_q <= run_q;
			end
			run_q <= 8'h00;
		end
	end
endmodule

// ### dv/afs_port_select_tb_top.sv
`timescale 1ns/1ns
module afs_port_select_tb_top;
	typedef struct packed {
		logic [3:0]  kind;  // Which result
		logic [15:0] val;   // Expected value
	} afs_note_t;
	localparam int unsigned STEP = 2;           // Cycles per dimming slot
	localparam int unsigned PER  = STEP * 100;  // Dimming period
	logic        sys_clk = 1'b0;          // Clock
	logic        rst_b = 1'b0;            // Reset, active low
	logic [3:0]  addr = 4'h0;             // Register address
	logic [15:0] wr_data = 16'h0000;      // Write data
	logic        wr_en = 1'b0;            // Write strobe
	logic        rd_en = 1'b0;            // Read strobe
	logic        uart_txd = 1'b1;         // Core serial data
	logic        energy_tick = 1'b0;      // Energy tick
	logic [6:0]  dim_pct = 7'h00;         // Dim level
	logic        load_state = 1'b0;       // Load switch
	logic        remote_on_cmd = 1'b0;    // Serial on command
	logic [15:0] panel_v = 16'h0000;      // Panel voltage
	logic        rx_lvl = 1'b1;           // Far switch level
	logic [15:0] rd_data;                 // Read data
	logic        rx_pin;                  // Receive pin
	logic        tx_pin;                  // Transmit pin
	logic        charge_en;               // Charger allowed
	logic        load_on_req;             // Load permitted
	logic        load_jumper;             // Jumper sensed
	logic        relay_on;                // Relay drive
	logic [7:0]  low_len;                 // Measured pulse width
	logic [15:0] hc;                      // High cycles in a period
	logic [15:0] rnd = 16'h0A5C;          // Random state
	afs_note_t   notes [$];               // Expected results
	afs_note_t   nt;                      // Note under test
	int          error_cnt = 0;           // Mismatches
	int          n_checks = 0;            // Comparisons
	string       nm [8] = '{"RD_DATA", "TX_PIN", "CHARGE_EN", "LOAD_ON_REQ",
		"LOAD_JUMPER", "RELAY_ON", "PULSE_LEN", "PWM_HIGH"};
	wire  [4:0]  obs = {relay_on, load_jumper, load_on_req, charge_en, tx_pin};  // Single-bit results
	logic [15:0] pv [4] = '{16'h0050, 16'h00C8, 16'h0050, 16'h0014};           // Panel steps
	logic [3:0]  pv_rly = 4'h6;                                                 // Relay after each step

	afs_port_select #(.PULSE_CYC(20), .PWM_STEP_CYC(STEP), .RELAY_HOLD_CYC(16), .RX_IDLE_CYC(8)) i_dut (
		.SYS_CLK(sys_clk), .RST_B(rst_b), .ADDR(addr), .WR_DATA(wr_data), .WR_EN(wr_en),
		.RD_EN(rd_en), .RD_DATA(rd_data), .RX_PIN(rx_pin), .TX_PIN(tx_pin), .UART_TXD(uart_txd),
		.ENERGY_TICK(energy_tick), .DIM_PCT(dim_pct), .LOAD_STATE(load_state),
		.REMOTE_ON_CMD(remote_on_cmd), .PANEL_V(panel_v), .CHARGE_EN(charge_en),
		.LOAD_ON_REQ(load_on_req), .LOAD_JUMPER(load_jumper), .RELAY_ON(relay_on));
	afs_far_model i_far (.clk(sys_clk), .rst_b(rst_b), .tx_pin(tx_pin), .rx_lvl(rx_lvl),
		.rx_pin(rx_pin), .low_len_q(low_len));

	// Clock, 20 ns period
	always #10 sys_clk = ~sys_clk;

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// Observed value for one kind of result
	function automatic logic [15:0] seen(input logic [3:0] k);
		seen = (k == 4'h0) ? rd_data : (k == 4'h6) ? {8'h00, low_len} : (k == 4'h7) ? hc : {15'h0000, obs[k - 4'h1]};
	endfunction
	task automatic cmp(input logic [3:0] k, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", nm[k], e, g);
		end
	endtask
	task automatic ex(input logic [3:0] k, input logic [15:0] v);
		notes.push_back('{k, v});
	endtask
	task automatic clk_n(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		wr_en <= 1'b1;
		addr <= a;
		wr_data <= d;
		clk_n(1);
		wr_en <= 1'b0;
		clk_n(1);
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		rd_en <= 1'b1;
		addr <= a;
		clk_n(1);
		rd_en <= 1'b0;
		ex(4'h0, e);
		clk_n(1);
	endtask
	// Random serial bits must appear on the pin one cycle later
	task automatic ser(input int n);
		repeat (n) begin
			rnd = lfsr(rnd);
			uart_txd <= rnd[0];
			clk_n(1);
			ex(4'h1, {15'h0000, rnd[0]});
		end
	endtask
	// Count high cycles of the pin over one dimming period
	task automatic hcount(input logic [15:0] e);
		hc = 16'h0000;
		repeat (PER) begin
			@(negedge sys_clk);
			hc = hc + {15'h0000, tx_pin};
		end
		clk_n(1);
		ex(4'h7, e);
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Checker: each settled result against the oldest note
	always @(negedge sys_clk) begin
		while (notes.size() > 0) begin
			nt = notes.pop_front();
			cmp(nt.kind, nt.val, seen(nt.kind));
		end
	end

	// Watchdog against a hang
	initial begin
		#400000;
		error_cnt++;
		conclude();
	end

	// Main sequence
	initial begin
		clk_n(16);
		rst_b <= 1'b1;
		clk_n(2);
		rd(afs_pkg::OFS_CTRL, 16'h0000);
		rd(afs_pkg::OFS_PV_SET, 16'hFFFF);
		rd(afs_pkg::OFS_PV_CLR, 16'h0000);
		rd(afs_pkg::OFS_STATUS, 16'h001D);
		ser(12);
		wr(4'h9, 16'h1234);
		rd(4'h9, 16'h0000);
		wr(afs_pkg::OFS_CTRL, 16'hFFFF);
		rd(afs_pkg::OFS_CTRL, 16'h007F);
		wr(afs_pkg::OFS_CTRL, 16'h0001);
		clk_n(3);
		ex(4'h1, 16'h0001);
		energy_tick <= 1'b1;
		clk_n(1);
		energy_tick <= 1'b0;
		clk_n(40);
		ex(4'h6, 16'h0014);
		for (int m = 2; m < 4; m++) begin
			for (int j = 0; j < 2; j++) begin
				wr(afs_pkg::OFS_CTRL, 16'(m));
				dim_pct <= (j == 0) ? 7'h64 : 7'h25;
				clk_n(4);
				hcount(16'((m == 3) ? PER - STEP * ((j == 0) ? 100 : 37) : STEP * ((j == 0) ? 100 : 37)));
			end
		end
		wr(afs_pkg::OFS_CTRL, 16'h0004);
		for (int i = 0; i < 2; i++) begin
			load_state <= i[0];
			clk_n(3);
			ex(4'h1, 16'(i));
		end
		rx_lvl <= 1'b0;
		clk_n(5);
		ser(6);
		rx_lvl <= 1'b1;
		ser(3);
		uart_txd <= 1'b0;
		clk_n(16);
		ex(4'h1, 16'h0001);
		for (int m = 0; m < 4; m++) begin
			wr(afs_pkg::OFS_CTRL, 16'(m * 8));
			for (int l = 0; l < 2; l++) begin
				rx_lvl <= l[0];
				clk_n(5);
				ex(4'h2, 16'((m != 0) || (l != 0)));
				ex(4'h3, 16'((m == 2) ? (l == 0) : (m == 3) ? l : 1));
				if (m == 1) begin
					ex(4'h4, 16'(l == 0));
				end
			end
		end
		remote_on_cmd <= 1'b1;
		rx_lvl <= 1'b0;
		wr(afs_pkg::OFS_CTRL, 16'h0000);
		clk_n(5);
		ex(4'h2, 16'h0001);
		rx_lvl <= 1'b1;
		wr(afs_pkg::OFS_CTRL, 16'h0040);
		load_state <= 1'b1;
		clk_n(10);
		load_state <= 1'b0;
		clk_n(10);
		ex(4'h5, 16'h0000);
		load_state <= 1'b1;
		clk_n(10);
		ex(4'h5, 16'h0000);
		clk_n(10);
		ex(4'h5, 16'h0001);
		// Reset in mid-run: outputs fall back, then the relay filter starts afresh
		clk_n(1);
		rst_b <= 1'b0;
		clk_n(2);
		rst_b <= 1'b1;
		ex(4'h1, 16'h0001);
		ex(4'h2, 16'h0000);
		ex(4'h5, 16'h0000);
		rd(afs_pkg::OFS_CTRL, 16'h0000);
		wr(afs_pkg::OFS_CTRL, 16'h0040);
		clk_n(20);
		ex(4'h5, 16'h0001);
		wr(afs_pkg::OFS_CTRL, 16'h0000);
		clk_n(1);
		ex(4'h5, 16'h0000);
		clk_n(20);
		ex(4'h5, 16'h0000);
		wr(afs_pkg::OFS_PV_SET, 16'h0064);
		wr(afs_pkg::OFS_PV_CLR, 16'h0032);
		wr(afs_pkg::OFS_CTRL, 16'h0020);
		for (int i = 0; i < 4; i++) begin
			panel_v <= pv[i];
			clk_n(22);
			ex(4'h5, {15'h0000, pv_rly[i]});
		end
		clk_n(2);
		conclude();
	end
endmodule
